//--- rtl/rtc_serial_port.sv
/*
 * Serial register access front end of a real-time clock, with a small
 * write FIFO between the serial side and the commit side.
 * Assumes SPI mode 3 framing (clock idles high, input sampled on rising
 * edges, output changed on falling edges), a serial clock well below a
 * quarter of clk_sys_in, and a one-cycle seconds tick on clk_sys_in.
 */
// Overview of operation
// - Command byte MSB first; bit seven reads
// - Bit six picks clock or RAM space
// - Bits five to one give the index
// - Command bit zero low blocks all writes
// - Code 3Fh bursts time bytes then control
// - Clock burst commits only after eight bytes
// - Code 7Fh bursts 31 RAM bytes from first
// - Each whole RAM burst byte stored immediately
// - RAM burst read stops after 31 bytes
// - Time writes buffered; incomplete writes discarded
// - Buffer loads together after chip select rises
// - Time load never coincides with seconds tick
// - Hours bit seven twelve-hour, bit five meridiem or twenty-hour digit
// - Write protect blocks all but itself
// - Control bits zero to six read zero
// - Century outside bursts, resets to nineteen
// - Single read latches counters on falling edge
// - Burst read latches time, sends control last
// - Burst read code BFh, data MSB first
`timescale 1ns/1ps

module rtc_byte_fifo #(
    parameter int unsigned WIDTH = 14,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic             clk_sys_in,
    input  wire logic             srst_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Whole FIFO state in one record
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;     // Storage
        logic [AW-1:0]               wr_ptr;  // Next write slot
        logic [AW-1:0]               rd_ptr;  // Next read slot
        logic [AW:0]                 count;   // Words held
    } fifo_state_s;

    fifo_state_s fifo_reg;   // Current state
    fifo_state_s fifo_next;  // Next state

    // Flags straight from the count, so full and empty are exact
    // Count is one bit wider than the pointers, so the depth is cast to that width
    assign in_ready_out  = (fifo_reg.count != (AW+1)'(DEPTH));
    assign out_valid_out = (fifo_reg.count != '0);
    assign out_data_out  = fifo_reg.mem[fifo_reg.rd_ptr];

    // Pointer and count update
    always_comb begin
        logic push;
        logic pop;
        push      = in_valid_in && in_ready_out;
        pop       = out_valid_out && out_ready_in;
        fifo_next = fifo_reg;
        if (push) begin
            fifo_next.mem[fifo_reg.wr_ptr] = in_data_in;
            fifo_next.wr_ptr = (fifo_reg.wr_ptr == AW'(DEPTH - 1)) ? '0
                                                                    : fifo_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            fifo_next.rd_ptr = (fifo_reg.rd_ptr == AW'(DEPTH - 1)) ? '0
                                                                    : fifo_reg.rd_ptr + 1'b1;
        end
        // Simultaneous push and pop leaves the count alone
        if (push && !pop) begin
            fifo_next.count = fifo_reg.count + 1'b1;
        end else if (pop && !push) begin
            fifo_next.count = fifo_reg.count - 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            fifo_reg <= '0;
        end else begin
            fifo_reg <= fifo_next;
        end
    end
endmodule

module rtc_serial_port (
    input  wire logic         clk_sys_in,
    input  wire logic         srst_in,
    input  wire logic         sclk_in,
    input  wire logic         cs_n_in,
    input  wire logic         mosi_in,
    input  wire logic         sec_tick_in,
    output logic              miso_out,
    output logic              miso_oe_out,
    output rtc_pkg::time_t    time_out,
    output logic        [7:0] century_out,
    output logic              write_protect_out,
    output logic              hour_mode_12_out,
    output logic              meridiem_flag_out,
    output logic              twenty_hour_digit_out
);
    localparam int unsigned WORD_W = $bits(rtc_pkg::wr_word_s);

    // Whole block state in one record
    typedef struct packed {
        logic [2:0]                        sclk_sync;  // Synchroniser plus edge stage
        logic [2:0]                        cs_sync;    // Synchroniser plus edge stage
        logic [1:0]                        mosi_sync;  // Synchroniser
        rtc_pkg::phase_e                   phase;      // Command or data
        logic [7:0]                        cmd;        // Command byte held
        logic [7:0]                        shift_in;   // Receive shifter
        logic [2:0]                        bit_cnt;    // Bits of current byte
        logic [5:0]                        byte_cnt;   // Data bytes received
        logic [5:0]                        out_cnt;    // Data bytes sent
        logic [7:0]                        shift_out;  // Transmit shifter
        logic                              miso;       // Serial output
        logic                              miso_oe;    // Output driven
        logic                              pend_valid; // Byte waiting for FIFO
        rtc_pkg::wr_word_s                 pend_word;  // That byte
        rtc_pkg::time_t                    live;       // Running counters
        rtc_pkg::time_t                    snap;       // Read holding latch
        logic [7:0]                        century;    // Century digits
        logic                              wp;         // Write protect
        logic [rtc_pkg::SLOTS-1:0][7:0]    wbuf;       // Time input buffer
        logic [rtc_pkg::SLOTS-1:0]         wmask;      // Slots written
        logic                              end_pend;   // Frame ended, commit due
        logic                              end_ok;     // Frame was complete
    } port_state_s;

    port_state_s       st_reg;       // Current state
    port_state_s       st_next;      // Next state
    logic [7:0]        ram [31];     // Scratchpad, undefined at power-up
    logic              ram_we;       // Scratchpad write strobe
    logic [4:0]        ram_waddr;    // Scratchpad write address
    logic [7:0]        ram_wdata;    // Scratchpad write data
    logic [4:0]        ram_raddr;    // Scratchpad read address
    logic [7:0]        ram_rdata;    // Scratchpad read data
    logic              fifo_ready;   // FIFO can take pending byte
    logic              fifo_valid;   // FIFO holds a word
    logic              drain_ready;  // Commit side accepts a word
    rtc_pkg::wr_word_s fifo_word;    // Word at FIFO head

    // BCD increment with wrap to zero
    function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] top);
        logic [7:0] r;
        r = v;
        if (v == top) begin
            r = rtc_pkg::BYTE_ZERO;
        end else if (v[3:0] == 4'h9) begin
            r = {v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction

    // Map a clock-space index to a buffer slot, or flag it as unused
    function automatic logic [4:0] slot_of(input logic [4:0] idx);
        logic [4:0] s;
        s = rtc_pkg::IDX_BURST;
        if (idx <= rtc_pkg::IDX_CTRL) begin
            s = idx;
        end else if (idx == rtc_pkg::IDX_CENTURY) begin
            s = {1'b0, rtc_pkg::SLOT_CENTURY};
        end
        return s;
    endfunction

    // Commit side drains except in a tick cycle, which keeps loads off the tick
    assign drain_ready = !sec_tick_in;

    rtc_byte_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (4)
    ) u_fifo (
        .clk_sys_in    (clk_sys_in),
        .srst_in       (srst_in),
        .in_valid_in   (st_reg.pend_valid),
        .in_ready_out  (fifo_ready),
        .in_data_in    (st_reg.pend_word),
        .out_valid_out (fifo_valid),
        .out_ready_in  (drain_ready),
        .out_data_out  (fifo_word)
    );

    assign ram_rdata = ram[ram_raddr];

    // Main next-state logic
    always_comb begin
        logic           rise;
        logic           fall;
        logic           cs_act;
        logic           cs_rise;
        logic           burst;
        logic           is_read;
        logic [7:0]     sh;
        logic [4:0]     idx;
        logic [4:0]     slot;
        logic [7:0]     obyte;
        rtc_pkg::time_t tsrc;
        rise      = 1'b0;
        fall      = 1'b0;
        cs_act    = 1'b0;
        cs_rise   = 1'b0;
        burst     = 1'b0;
        is_read   = 1'b0;
        sh        = rtc_pkg::BYTE_ZERO;
        idx       = '0;
        slot      = '0;
        obyte     = rtc_pkg::BYTE_ZERO;
        tsrc      = '0;
        ram_we    = 1'b0;
        ram_waddr = '0;
        ram_wdata = rtc_pkg::BYTE_ZERO;
        ram_raddr = '0;
        st_next   = st_reg;

        // Pin synchronisers; values from the second stage, edges from second against third
        st_next.sclk_sync = {st_reg.sclk_sync[1:0], sclk_in};
        st_next.cs_sync   = {st_reg.cs_sync[1:0], cs_n_in};
        st_next.mosi_sync = {st_reg.mosi_sync[0], mosi_in};
        rise    = st_reg.sclk_sync[1] && !st_reg.sclk_sync[2];
        fall    = !st_reg.sclk_sync[1] && st_reg.sclk_sync[2];
        cs_act  = !st_reg.cs_sync[1];
        cs_rise = st_reg.cs_sync[1] && !st_reg.cs_sync[2];
        burst   = (st_reg.cmd[rtc_pkg::CMD_IDX_HI:rtc_pkg::CMD_IDX_LO]
                   == rtc_pkg::IDX_BURST);
        is_read = st_reg.cmd[rtc_pkg::CMD_READ_BIT];

        // Pending byte leaves once the FIFO takes it
        if (st_reg.pend_valid && fifo_ready) begin
            st_next.pend_valid = 1'b0;
        end

        // Live counters: the tick always wins, commit waits a cycle
        if (sec_tick_in) begin
            st_next.live[0] = bcd_inc(st_reg.live[0], rtc_pkg::BCD_59);
            if (st_reg.live[0] == rtc_pkg::BCD_59) begin
                st_next.live[1] = bcd_inc(st_reg.live[1], rtc_pkg::BCD_59);
            end
        end else if (st_reg.end_pend && !fifo_valid && !st_reg.pend_valid) begin
            // All buffered bytes land in one cycle, or none do
            if (st_reg.end_ok) begin
                for (int i = 0; i < rtc_pkg::TIME_BYTES; i++) begin
                    if (st_reg.wmask[i]) begin
                        st_next.live[i] = st_reg.wbuf[i];
                    end
                end
                if (st_reg.wmask[rtc_pkg::SLOT_CTRL]) begin
                    st_next.wp = st_reg.wbuf[rtc_pkg::SLOT_CTRL][rtc_pkg::CTRL_WP_BIT];
                end
                if (st_reg.wmask[rtc_pkg::SLOT_CENTURY]) begin
                    st_next.century = st_reg.wbuf[rtc_pkg::SLOT_CENTURY];
                end
            end
            st_next.wmask    = '0;
            st_next.end_pend = 1'b0;
        end

        // Commit side: RAM bytes go straight in, clock bytes to the buffer
        if (fifo_valid && drain_ready) begin
            if (fifo_word.ram) begin
                ram_we    = 1'b1;
                ram_waddr = fifo_word.idx;
                ram_wdata = fifo_word.data;
            end else begin
                st_next.wbuf[fifo_word.idx[3:0]]  = fifo_word.data;
                st_next.wmask[fifo_word.idx[3:0]] = 1'b1;
            end
        end

        // Frame end: judge completeness against the state just before it
        if (cs_rise && st_reg.phase == rtc_pkg::PH_DATA && !is_read) begin
            st_next.end_pend = 1'b1;
            st_next.end_ok   = (st_reg.bit_cnt == '0)
                               && (st_reg.cmd[rtc_pkg::CMD_RAM_BIT] || !burst
                                   || st_reg.byte_cnt >= rtc_pkg::CLOCK_BURST_BYTES);
        end

        if (!cs_act) begin
            // Idle: release the output and forget the frame
            st_next.phase    = rtc_pkg::PH_CMD;
            st_next.bit_cnt  = '0;
            st_next.byte_cnt = '0;
            st_next.out_cnt  = '0;
            st_next.miso_oe  = 1'b0;
        end else if (rise) begin
            // Sample input, MSB first
            sh = {st_reg.shift_in[6:0], st_reg.mosi_sync[1]};
            st_next.shift_in = sh;
            st_next.bit_cnt  = st_reg.bit_cnt + 3'h1;
            if (st_reg.bit_cnt == rtc_pkg::BIT_LAST) begin
                unique case (st_reg.phase)
                    rtc_pkg::PH_CMD: begin
                        st_next.cmd   = sh;
                        st_next.phase = rtc_pkg::PH_DATA;
                    end
                    rtc_pkg::PH_DATA: begin
                        if (!is_read && st_reg.cmd[rtc_pkg::CMD_ENABLE_BIT]) begin
                            idx = burst ? st_reg.byte_cnt[4:0]
                                        : st_reg.cmd[rtc_pkg::CMD_IDX_HI:rtc_pkg::CMD_IDX_LO];
                            if (st_reg.cmd[rtc_pkg::CMD_RAM_BIT]) begin
                                // Scratchpad: first whole byte, or any of the first 31 in a burst, never under protect
                                if (!st_reg.wp && (burst || st_reg.byte_cnt == '0)
                                    && st_reg.byte_cnt < rtc_pkg::RAM_WORDS) begin
                                    st_next.pend_valid = 1'b1;
                                    st_next.pend_word  = '{ram: 1'b1, idx: idx, data: sh};
                                end
                            end else begin
                                // Clock space; control stays writable under protect
                                slot = slot_of(idx);
                                if ((burst ? st_reg.byte_cnt < rtc_pkg::CLOCK_BURST_BYTES
                                           : st_reg.byte_cnt == '0)
                                    && slot != rtc_pkg::IDX_BURST
                                    && (!st_reg.wp || slot == rtc_pkg::IDX_CTRL)) begin
                                    st_next.pend_valid = 1'b1;
                                    st_next.pend_word  = '{ram: 1'b0, idx: slot, data: sh};
                                end
                            end
                        end
                        if (st_reg.byte_cnt != rtc_pkg::BYTE_CNT_MAX) begin
                            st_next.byte_cnt = st_reg.byte_cnt + 6'h01;
                        end
                    end
                endcase
            end
        end else if (fall && st_reg.phase == rtc_pkg::PH_DATA && is_read) begin
            st_next.miso_oe = 1'b1;
            if (st_reg.bit_cnt == '0) begin
                // First fall of a byte: latch counters once, load next byte
                tsrc = (st_reg.out_cnt == '0) ? st_next.live : st_reg.snap;
                if (st_reg.out_cnt == '0) begin
                    st_next.snap = st_next.live;
                end
                idx = burst ? st_reg.out_cnt[4:0]
                            : st_reg.cmd[rtc_pkg::CMD_IDX_HI:rtc_pkg::CMD_IDX_LO];
                if (st_reg.cmd[rtc_pkg::CMD_RAM_BIT]) begin
                    ram_raddr = idx;
                    if (st_reg.out_cnt < rtc_pkg::RAM_WORDS || !burst) begin
                        obyte = (idx < rtc_pkg::IDX_BURST) ? ram_rdata : rtc_pkg::BYTE_ZERO;
                    end
                end else if (!burst || st_reg.out_cnt < rtc_pkg::CLOCK_BURST_BYTES) begin
                    if (idx <= rtc_pkg::IDX_YEAR) begin
                        obyte = tsrc[idx[2:0]];
                    end else if (idx == rtc_pkg::IDX_CTRL) begin
                        obyte = {st_reg.wp, 7'h00};
                    end else if (idx == rtc_pkg::IDX_CENTURY) begin
                        obyte = st_reg.century;
                    end
                end
                st_next.shift_out = obyte;
                st_next.miso      = obyte[7];
                if (st_reg.out_cnt != rtc_pkg::BYTE_CNT_MAX) begin
                    st_next.out_cnt = st_reg.out_cnt + 6'h01;
                end
            end else begin
                // Later falls: next bit down
                st_next.shift_out = {st_reg.shift_out[6:0], 1'b0};
                st_next.miso      = st_reg.shift_out[6];
            end
        end
    end

    // State register with power-on style values
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            st_reg           <= '0;
            st_reg.sclk_sync <= 3'h7;
            st_reg.cs_sync   <= 3'h7;
            st_reg.century   <= rtc_pkg::CENTURY_RESET;
            for (int i = 0; i < rtc_pkg::TIME_BYTES; i++) begin
                st_reg.live[i] <= rtc_pkg::TIME_RESET;
            end
        end else begin
            st_reg <= st_next;
        end
    end

    // Scratchpad storage; contents survive reset on purpose
    always_ff @(posedge clk_sys_in) begin
        if (ram_we) begin
            ram[ram_waddr] <= ram_wdata;
        end
    end

    // Outputs from flip-flops; meridiem and twenty-hour flags each through one gate
    assign miso_out              = st_reg.miso;
    assign miso_oe_out           = st_reg.miso_oe;
    assign time_out              = st_reg.live;
    assign century_out           = st_reg.century;
    assign write_protect_out     = st_reg.wp;
    assign hour_mode_12_out      = st_reg.live[2][rtc_pkg::HOUR_MODE_BIT];
    assign meridiem_flag_out     = st_reg.live[2][rtc_pkg::HOUR_MODE_BIT]
                                   && st_reg.live[2][rtc_pkg::HOUR_BIT5];
    assign twenty_hour_digit_out = !st_reg.live[2][rtc_pkg::HOUR_MODE_BIT]
                                   && st_reg.live[2][rtc_pkg::HOUR_BIT5];
endmodule

//--- rtl/rtc_pkg.sv
/*
 * Shared constants and types for the serial clock access block.
 * Assumes a single system clock; nothing here holds state.
 */
package rtc_pkg;

    // Command byte field positions
    localparam int unsigned CMD_READ_BIT   = 7;          // 1 = read, 0 = write
    localparam int unsigned CMD_RAM_BIT    = 6;          // 1 = scratchpad, 0 = clock space
    localparam int unsigned CMD_IDX_HI     = 5;          // Index field top
    localparam int unsigned CMD_IDX_LO     = 1;          // Index field bottom
    localparam int unsigned CMD_ENABLE_BIT = 0;          // Must be 1 for writes

    // Register indices (command bits 5..1)
    localparam logic [4:0] IDX_SEC     = 5'h00;
    localparam logic [4:0] IDX_MIN     = 5'h01;
    localparam logic [4:0] IDX_YEAR    = 5'h06;
    localparam logic [4:0] IDX_CTRL    = 5'h07;
    localparam logic [4:0] IDX_CENTURY = 5'h09;
    localparam logic [4:0] IDX_BURST   = 5'h1F;          // Burst code in either space

    // Buffer slots: seven time bytes, control, century
    localparam logic [3:0] SLOT_CTRL    = 4'h7;
    localparam logic [3:0] SLOT_CENTURY = 4'h8;
    localparam int unsigned SLOTS       = 9;
    localparam int unsigned TIME_BYTES  = 7;

    // Counts
    localparam logic [5:0] CLOCK_BURST_BYTES = 6'h08;
    localparam logic [5:0] RAM_WORDS         = 6'h1F;    // 31 scratchpad bytes
    localparam logic [5:0] BYTE_CNT_MAX      = 6'h3F;
    localparam logic [2:0] BIT_LAST          = 3'h7;

    // Field positions
    localparam int unsigned CTRL_WP_BIT    = 7;
    localparam int unsigned HOUR_MODE_BIT  = 7;
    localparam int unsigned HOUR_BIT5      = 5;

    // Reset and wrap values
    localparam logic [7:0] TIME_RESET    = 8'h00;
    localparam logic [7:0] CENTURY_RESET = 8'h19;
    localparam logic [7:0] BCD_59        = 8'h59;
    localparam logic [7:0] BYTE_ZERO     = 8'h00;

    // Live time, index 0 = seconds .. 6 = year
    typedef logic [TIME_BYTES-1:0][7:0] time_t;

    // Word queued from the serial side to the commit side
    typedef struct packed {
        logic       ram;    // Scratchpad target
        logic [4:0] idx;    // RAM location or buffer slot
        logic [7:0] data;   // Byte received
    } wr_word_s;

    // Frame phase
    typedef enum logic {
        PH_CMD  = 1'b0,
        PH_DATA = 1'b1
    } phase_e;

endpackage

//--- verif/rtc_serial_port_properties.sv
/* Concurrent checks on the serial port's outputs.
   Assumes the bind below and a synchronous active-high reset. */
`timescale 1ns/1ps
module rtc_serial_port_properties (
    input wire logic           clk_sys_in,
    input wire logic           srst_in,
    input wire logic           cs_n_in,
    input wire logic           sec_tick_in,
    input wire logic           miso_oe_out,
    input wire rtc_pkg::time_t time_out,
    input wire logic     [7:0] century_out,
    input wire logic           write_protect_out,
    input wire logic           hour_mode_12_out,
    input wire logic           meridiem_flag_out,
    input wire logic           twenty_hour_digit_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);
    // Chip select high long enough to pass the synchroniser
    sequence s_idle;
        cs_n_in [*5];
    endsequence
    a_reset_century: assert property (disable iff (1'b0) srst_in |=> century_out == 8'h19)
        else $error("century not 19h after reset");
    a_mode_flag: assert property ($stable(time_out[2]) |-> hour_mode_12_out == time_out[2][7])
        else $error("twelve hour flag wrong");
    a_meridiem_flag: assert property ($stable(time_out[2])
        |-> meridiem_flag_out == (time_out[2][7] & time_out[2][5]))
        else $error("meridiem flag wrong");
    a_twenty_digit: assert property ($stable(time_out[2])
        |-> twenty_hour_digit_out == (!time_out[2][7] & time_out[2][5]))
        else $error("twenty hour digit wrong");
    a_idle_released: assert property (s_idle |-> !miso_oe_out)
        else $error("miso driven outside a frame");
    a_tick_moves: assert property (sec_tick_in |=> time_out[0] != $past(time_out[0]))
        else $error("seconds tick lost");
    // Time may move only by tick or by a commit after chip select rises
    a_time_commit: assert property (($changed(time_out) && !$past(sec_tick_in)) |-> cs_n_in)
        else $error("time changed inside a frame");
    a_wp_commit: assert property ($changed(write_protect_out) |-> cs_n_in)
        else $error("write protect changed inside a frame");
endmodule
bind rtc_serial_port rtc_serial_port_properties u_props (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .cs_n_in(cs_n_in),
    .sec_tick_in(sec_tick_in), .miso_oe_out(miso_oe_out), .time_out(time_out),
    .century_out(century_out), .write_protect_out(write_protect_out),
    .hour_mode_12_out(hour_mode_12_out), .meridiem_flag_out(meridiem_flag_out),
    .twenty_hour_digit_out(twenty_hour_digit_out)
);

//--- verif/spi_master_model.sv
/* Mode 3 serial host model: 200 ns clock, MSB first.
   Assumes the bench fills tx before a frame and reads rx after it. */
`timescale 1ns/1ps
module spi_master_model (
    input  wire logic clk_sys_in,
    input  wire logic miso_in,
    input  wire logic miso_oe_in,
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      mosi_out
);
    logic [7:0] tx [8]; // Bytes after the command
    logic [7:0] rx [8]; // Bytes seen on miso
    initial begin
        sclk_out = 1'b1;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    // Half serial period, always just after a clock edge
    task automatic half();
        repeat (4) @(posedge clk_sys_in);
        #1;
    endtask
    // Command then n whole bytes framed by chip select
    task automatic frame(input logic [7:0] cmd, input int n);
        logic [7:0] b;
        logic [7:0] r;
        half();
        cs_n_out = 1'b0;
        half();
        for (int k = 0; k <= n; k++) begin
            b = (k == 0) ? cmd : tx[k-1];
            for (int i = 7; i >= 0; i--) begin
                sclk_out = 1'b0;
                mosi_out = b[i];
                half();
                sclk_out = 1'b1;
                half();
                r = {r[6:0], miso_oe_in ? miso_in : 1'bx};
            end
            if (k > 0) rx[k-1] = r;
        end
        cs_n_out = 1'b1;
        mosi_out = ~mosi_out; // Released line must not hold its last value
        repeat (3) half();
    endtask
endmodule

//--- verif/rtc_serial_port_test.sv
/* Bench: host model, tick source and expected values.
   Assumes the checker binds itself from its own file. */
`timescale 1ns/1ps
module rtc_serial_port_test;
    logic           clk_sys_in;
    logic           srst_in;
    logic           sec_tick_in;
    logic           sclk, cs_n, mosi, miso, oe, wp, h12, mer, twenty;
    rtc_pkg::time_t tv;
    logic     [7:0] cent;
    int             errors = 0;
    int             checks = 0;
    logic     [7:0] set_v [8] = '{8'h31, 8'h11, 8'hB0, 8'h04, 8'h07, 8'h05, 8'h02, 8'h00};
    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    rtc_serial_port DUT (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .sclk_in(sclk),
        .cs_n_in(cs_n), .mosi_in(mosi), .sec_tick_in(sec_tick_in), .miso_out(miso),
        .miso_oe_out(oe), .time_out(tv), .century_out(cent), .write_protect_out(wp),
        .hour_mode_12_out(h12), .meridiem_flag_out(mer), .twenty_hour_digit_out(twenty));
    spi_master_model u_m (.clk_sys_in(clk_sys_in), .miso_in(miso), .miso_oe_in(oe),
        .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
        u_m.tx[0] = d;
        u_m.frame(cmd, 1);
    endtask
    task automatic end_of_test();
        $display("Checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Watchdog well past the expected run
    initial begin
        #1000000;
        errors++;
        end_of_test();
    end
    initial begin
        srst_in = 1'b1;
        sec_tick_in = 1'b0;
        repeat (20) @(posedge clk_sys_in);
        #1 srst_in = 1'b0;
        repeat (8) @(posedge clk_sys_in);
        check(cent, 8'h19);
        u_m.tx = set_v;
        u_m.frame(8'h3F, 8);
        for (int k = 0; k < 7; k++) check(tv[k], set_v[k]);
        check(mer, 1'b1);
        u_m.frame(8'hBF, 8);
        for (int k = 0; k < 8; k++) check(u_m.rx[k], set_v[k]);
        u_m.tx[0] = 8'h55;
        u_m.frame(8'h3F, 3);
        check(tv[0], 8'h31);
        wr(8'h02, 8'h45);
        check(tv[1], 8'h11);
        wr(8'h81, 8'h00);
        check(u_m.rx[0], 8'h31);
        wr(8'h03, 8'h45);
        wr(8'h83, 8'h00);
        check(u_m.rx[0], 8'h45);
        wr(8'h81, 8'h00);
        check(u_m.rx[0], 8'h31);
        wr(8'h05, 8'h23);
        check(twenty, 1'b1);
        check(h12, 1'b0);
        wr(8'h13, 8'h20);
        check(cent, 8'h20);
        u_m.tx[0] = 8'hA5;
        u_m.frame(8'h7F, 3);
        wr(8'hC3, 8'h00);
        check(u_m.rx[0], 8'h11);
        u_m.frame(8'hFF, 3);
        check(u_m.rx[2], 8'hB0);
        wr(8'h0F, 8'hFF);
        check(wp, 1'b1);
        wr(8'h8F, 8'h00);
        check(u_m.rx[0], 8'h80);
        wr(8'h03, 8'h12);
        check(tv[1], 8'h45);
        wr(8'h41, 8'h77);
        wr(8'hC1, 8'h00);
        check(u_m.rx[0], 8'hA5);
        wr(8'h0F, 8'h00);
        check(wp, 1'b0);
        @(posedge clk_sys_in) #1 sec_tick_in = 1'b1;
        @(posedge clk_sys_in) #1 sec_tick_in = 1'b0;
        repeat (3) @(posedge clk_sys_in);
        check(tv[0], 8'h32);
        end_of_test();
    end
endmodule
